//--- verilog/fp_round_flags.sv
// rounding stage and sticky exception flags for scalar and simd fp units
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module fp_round_flags (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_r,
  input wire logic op_valid,
  input wire logic op_simd,
  input wire logic op_div,
  input wire logic op_trunc_conv,
  input wire logic op_no_round,
  input wire logic [31:0] opa,
  input wire logic [31:0] opb,
  input wire logic res_sign,
  input wire logic [9:0] res_exp,
  input wire logic [25:0] res_sig,
  output logic res_valid_r,
  output logic res_write_r,
  output logic [31:0] res_r,
  output logic handler_req_r,
  output logic [5:0] exc_seen_r
);
  function automatic logic is_zero(input logic [31:0] x);
    is_zero = (x[30:0] == 31'h00000000);
  endfunction : is_zero
  function automatic logic is_inf(input logic [31:0] x);
    is_inf = (x[30:23] == fp_round_pkg::EXP_MAX) && (x[22:0] == 23'h000000);
  endfunction : is_inf
  function automatic logic is_nan(input logic [31:0] x);
    is_nan = (x[30:23] == fp_round_pkg::EXP_MAX) && (x[22:0] != 23'h000000);
  endfunction : is_nan
  function automatic logic is_snan(input logic [31:0] x);
    is_snan = is_nan(x) && !x[22];
  endfunction : is_snan
  function automatic logic is_subnormal(input logic [31:0] x);
    is_subnormal = (x[30:23] == 8'h00) && (x[22:0] != 23'h000000);
  endfunction : is_subnormal
  // increment decision for one sign, lsb, guard and sticky under a mode
  function automatic logic round_up(input logic [1:0] rc, input logic sgn,
                                    input logic lsb, input logic g, input logic s);
    case (rc)
      fp_round_pkg::RC_NEAREST: round_up = g && (s || lsb);
      fp_round_pkg::RC_DOWN: round_up = sgn && (g || s);
      fp_round_pkg::RC_UP: round_up = !sgn && (g || s);
      default: round_up = 1'b0;
    endcase
  endfunction : round_up

  logic [5:0] sc_mask_r;
  logic [1:0] sc_rc_r;
  logic [5:0] sc_flag_r;
  logic [5:0] simd_mask_r;
  logic [1:0] simd_rc_r;
  logic [5:0] simd_flag_r;

  // register decode
  wire wr_sc_ctrl = reg_wr && (reg_addr == fp_round_pkg::OFS_SCALAR_CTRL);
  wire wr_sc_status = reg_wr && (reg_addr == fp_round_pkg::OFS_SCALAR_STATUS);
  wire wr_simd = reg_wr && (reg_addr == fp_round_pkg::OFS_SIMD_CSR);
  wire [31:0] sc_ctrl_word = (32'(sc_rc_r) << fp_round_pkg::SC_RC_LO)
                           | (32'(sc_mask_r) << fp_round_pkg::SC_MASK_LO);
  wire [31:0] simd_word = (32'(simd_rc_r) << fp_round_pkg::SIMD_RC_LO)
                        | (32'(simd_mask_r) << fp_round_pkg::SIMD_MASK_LO)
                        | (32'(simd_flag_r) << fp_round_pkg::SIMD_FLAG_LO);
  // unmapped reads answer zero
  wire [31:0] rd_sel = (reg_addr == fp_round_pkg::OFS_SCALAR_CTRL) ? sc_ctrl_word :
                       (reg_addr == fp_round_pkg::OFS_SCALAR_STATUS) ? 32'(sc_flag_r) :
                       (reg_addr == fp_round_pkg::OFS_SIMD_CSR) ? simd_word : 32'h00000000;
  wire [31:0] reg_rdata_nxt = reg_rd ? rd_sel : 32'h00000000;

  // per-unit selection of masks and rounding field
  wire [5:0] mask_sel = op_simd ? simd_mask_r : sc_mask_r;
  wire [1:0] rc_unit = op_simd ? simd_rc_r : sc_rc_r;
  // truncating conversions ignore the field
  wire [1:0] rc_sel = op_trunc_conv ? fp_round_pkg::RC_ZERO : rc_unit;

  // pre-computation detection from operands only
  wire pre_inv = is_snan(opa) || is_snan(opb)
               || (op_div && ((is_zero(opa) && is_zero(opb))
               || (is_inf(opa) && is_inf(opb))));
  wire pre_dz = op_div && is_zero(opb) && !is_zero(opa)
              && !is_inf(opa) && !is_nan(opa);
  wire pre_sub = is_subnormal(opa) || is_subnormal(opb);
  wire [2:0] pre_exc = {pre_dz, pre_sub, pre_inv};
  wire pre_trap = |(pre_exc & ~mask_sel[2:0]);

  // rounding between the two bracketing values
  wire r_lsb = res_sig[2];
  wire r_g = res_sig[1];
  wire r_s = res_sig[0];
  wire inc = !op_no_round && round_up(rc_sel, res_sign, r_lsb, r_g, r_s);
  wire [24:0] sum = {1'b0, res_sig[25:2]} + {24'h000000, inc};
  wire carry = sum[24];
  wire [23:0] mant = carry ? sum[24:1] : sum[23:0];
  wire promo = (res_exp == 10'h000) && sum[23];
  wire [9:0] exp_fin = res_exp + {9'h000, carry || promo};
  // post-computation detection from the rounded result
  wire inexact = !op_no_round && (r_g || r_s);
  wire ovf = !op_no_round && !exp_fin[9] && (exp_fin >= fp_round_pkg::EXP_OVF);
  wire unf = inexact && (exp_fin[9] || (exp_fin == 10'h000));
  // an unmasked pre-computation fault stops the instruction here
  wire [2:0] post_exc = {inexact, unf, ovf} & {3{!pre_trap}};
  wire [5:0] exc_all = {post_exc, pre_exc};
  wire trap = |(exc_all & ~mask_sel);

  // masked overflow picks infinity or largest finite
  wire ovf_to_inf = (rc_sel == fp_round_pkg::RC_NEAREST)
                  || ((rc_sel == fp_round_pkg::RC_DOWN) && res_sign)
                  || ((rc_sel == fp_round_pkg::RC_UP) && !res_sign);
  wire [31:0] ovf_res = {res_sign, ovf_to_inf ? fp_round_pkg::MAG_INF
                                              : fp_round_pkg::MAG_MAX_FINITE};
  wire [7:0] exp_pack = exp_fin[9] ? 8'h00 : exp_fin[7:0];
  wire [31:0] round_res = {res_sign, exp_pack, mant[22:0]};
  wire [31:0] res_nxt = pre_inv ? fp_round_pkg::QNAN_INDEFINITE :
                        pre_dz ? {opa[31] ^ opb[31], fp_round_pkg::MAG_INF} :
                        ovf ? ovf_res : round_res;

  // flags: a hardware set wins over a software clear in the same cycle
  wire [5:0] sc_set = (op_valid && !op_simd) ? exc_all : 6'h00;
  wire [5:0] simd_set = (op_valid && op_simd) ? exc_all : 6'h00;
  wire [5:0] sc_flag_nxt = (wr_sc_status ? reg_wdata[5:0] : sc_flag_r) | sc_set;
  wire [5:0] simd_flag_nxt = (wr_simd ? reg_wdata[fp_round_pkg::SIMD_FLAG_LO +: 6]
                                      : simd_flag_r) | simd_set;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sc_mask_r <= fp_round_pkg::MASK_RESET;
      sc_rc_r <= fp_round_pkg::RC_RESET;
      simd_mask_r <= fp_round_pkg::MASK_RESET;
      simd_rc_r <= fp_round_pkg::RC_RESET;
    end else begin
      if (wr_sc_ctrl) begin
        sc_mask_r <= reg_wdata[fp_round_pkg::SC_MASK_LO +: 6];
        sc_rc_r <= reg_wdata[fp_round_pkg::SC_RC_LO +: 2];
      end
      if (wr_simd) begin
        simd_mask_r <= reg_wdata[fp_round_pkg::SIMD_MASK_LO +: 6];
        simd_rc_r <= reg_wdata[fp_round_pkg::SIMD_RC_LO +: 2];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sc_flag_r <= fp_round_pkg::FLAG_RESET;
      simd_flag_r <= fp_round_pkg::FLAG_RESET;
      reg_rdata_r <= 32'h00000000;
    end else begin
      sc_flag_r <= sc_flag_nxt;
      simd_flag_r <= simd_flag_nxt;
      reg_rdata_r <= reg_rdata_nxt;
    end
  end

  // result stage, one cycle after the request
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      res_valid_r <= 1'b0;
      res_write_r <= 1'b0;
      res_r <= 32'h00000000;
      handler_req_r <= 1'b0;
      exc_seen_r <= 6'h00;
    end else begin
      res_valid_r <= op_valid;
      res_write_r <= op_valid && !trap;
      handler_req_r <= op_valid && trap;
      exc_seen_r <= op_valid ? exc_all : 6'h00;
      // on a trap the destination keeps its old value
      if (op_valid && !trap) begin
        res_r <= res_nxt;
      end
    end
  end

  sequence s_inv_unmasked;
    op_valid && pre_inv && !mask_sel[fp_round_pkg::BIT_INVALID];
  endsequence
  sequence s_trap_no_write;
    handler_req_r && !res_write_r && exc_seen_r[fp_round_pkg::BIT_INVALID];
  endsequence

  property p_unmasked_invalid;
    @(posedge clk) disable iff (!reset_n)
      s_inv_unmasked |=> s_trap_no_write ##0 $stable(res_r);
  endproperty
  a_unmasked_invalid: assert property (p_unmasked_invalid)
    else $error("unmasked invalid did not trap cleanly");

  property p_inexact_sets_flag;
    @(posedge clk) disable iff (!reset_n)
      op_valid && !op_simd && inexact |=> sc_flag_r[fp_round_pkg::BIT_PRECISION];
  endproperty
  a_inexact_sets_flag: assert property (p_inexact_sets_flag)
    else $error("inexact scalar result left precision flag clear");

  property p_sticky;
    @(posedge clk) disable iff (!reset_n)
      !wr_sc_status |=> (sc_flag_r & $past(sc_flag_r)) == $past(sc_flag_r);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("scalar flag dropped without a software write");

  property p_unmasked_trap;
    @(posedge clk) disable iff (!reset_n)
      op_valid && (|(exc_all & ~mask_sel)) |=> handler_req_r && !res_write_r;
  endproperty
  a_unmasked_trap: assert property (p_unmasked_trap)
    else $error("unmasked exception gave no handler request");

  property p_masked_continue;
    @(posedge clk) disable iff (!reset_n)
      op_valid && (exc_all != 6'h00) && ((exc_all & ~mask_sel) == 6'h00)
        |=> res_write_r && !handler_req_r ##1 !handler_req_r || res_valid_r;
  endproperty
  a_masked_continue: assert property (p_masked_continue)
    else $error("masked exception did not deliver a result");

  property p_trunc_no_inc;
    @(posedge clk) disable iff (!reset_n)
      op_valid && op_trunc_conv |-> !inc;
  endproperty
  a_trunc_no_inc: assert property (p_trunc_no_inc)
    else $error("truncating conversion rounded away from zero");

  property p_no_round_exact;
    @(posedge clk) disable iff (!reset_n)
      op_valid && op_no_round |=> !exc_seen_r[fp_round_pkg::BIT_PRECISION]
        && !exc_seen_r[fp_round_pkg::BIT_OVERFLOW];
  endproperty
  a_no_round_exact: assert property (p_no_round_exact)
    else $error("non-rounding operation raised a post flag");

  property p_simd_leaves_scalar;
    @(posedge clk) disable iff (!reset_n)
      op_valid && op_simd && !wr_sc_status |=> sc_flag_r == $past(sc_flag_r);
  endproperty
  a_simd_leaves_scalar: assert property (p_simd_leaves_scalar)
    else $error("simd operation touched scalar flags");

  property p_ovf_down_pos;
    @(posedge clk) disable iff (!reset_n)
      op_valid && ovf && !pre_inv && !pre_dz && !res_sign && !trap
        && (rc_sel == fp_round_pkg::RC_DOWN)
        |=> res_r == {1'b0, fp_round_pkg::MAG_MAX_FINITE};
  endproperty
  a_ovf_down_pos: assert property (p_ovf_down_pos)
    else $error("masked overflow toward minus gave wrong result");

  property p_tie_even;
    @(posedge clk) disable iff (!reset_n)
      op_valid && !op_no_round && (rc_sel == fp_round_pkg::RC_NEAREST)
        && r_g && !r_s |-> inc == r_lsb;
  endproperty
  a_tie_even: assert property (p_tie_even)
    else $error("tie not rounded to even");

  property p_nearest_above_half;
    @(posedge clk) disable iff (!reset_n)
      op_valid && !op_no_round && (rc_sel == fp_round_pkg::RC_NEAREST) && r_g && r_s |-> inc;
  endproperty
  a_nearest_above_half: assert property (p_nearest_above_half)
    else $error("nearest mode kept the farther value");

  property p_down_positive;
    @(posedge clk) disable iff (!reset_n)
      op_valid && (rc_sel == fp_round_pkg::RC_DOWN) && !res_sign |-> !inc;
  endproperty
  a_down_positive: assert property (p_down_positive)
    else $error("round down moved a positive result up");

  property p_up_negative;
    @(posedge clk) disable iff (!reset_n)
      op_valid && (rc_sel == fp_round_pkg::RC_UP) && res_sign |-> !inc;
  endproperty
  a_up_negative: assert property (p_up_negative)
    else $error("round up moved a negative result down");

  property p_zero_no_inc;
    @(posedge clk) disable iff (!reset_n)
      op_valid && (rc_sel == fp_round_pkg::RC_ZERO) |-> !inc;
  endproperty
  a_zero_no_inc: assert property (p_zero_no_inc)
    else $error("truncate mode grew the magnitude");

  // the field must only move on a software write, so reset value persists
  property p_sc_rc_hold;
    @(posedge clk) disable iff (!reset_n)
      !wr_sc_ctrl |=> $stable(sc_rc_r);
  endproperty
  a_sc_rc_hold: assert property (p_sc_rc_hold)
    else $error("scalar rounding field changed without a write");

  property p_exact_no_inc;
    @(posedge clk) disable iff (!reset_n)
      op_valid && !r_g && !r_s |-> !inc && !inexact;
  endproperty
  a_exact_no_inc: assert property (p_exact_no_inc)
    else $error("exact result was rounded");

  property p_simd_inexact_flag;
    @(posedge clk) disable iff (!reset_n)
      op_valid && op_simd && inexact |=> simd_flag_r[fp_round_pkg::BIT_PRECISION];
  endproperty
  a_simd_inexact_flag: assert property (p_simd_inexact_flag)
    else $error("inexact simd result left precision flag clear");

  property p_no_round_no_inc;
    @(posedge clk) disable iff (!reset_n)
      op_valid && op_no_round |-> !inc;
  endproperty
  a_no_round_no_inc: assert property (p_no_round_no_inc)
    else $error("non-rounding operation was rounded");

  property p_sc_rc_write;
    @(posedge clk) disable iff (!reset_n)
      wr_sc_ctrl |=> sc_rc_r == $past(reg_wdata[fp_round_pkg::SC_RC_LO +: 2]);
  endproperty
  a_sc_rc_write: assert property (p_sc_rc_write)
    else $error("scalar rounding field not taken from its bits");

  property p_simd_rc_write;
    @(posedge clk) disable iff (!reset_n)
      wr_simd |=> simd_rc_r == $past(reg_wdata[fp_round_pkg::SIMD_RC_LO +: 2]);
  endproperty
  a_simd_rc_write: assert property (p_simd_rc_write)
    else $error("simd rounding field not taken from its bits");

  property p_sc_mask_write;
    @(posedge clk) disable iff (!reset_n)
      wr_sc_ctrl |=> sc_mask_r == $past(reg_wdata[fp_round_pkg::SC_MASK_LO +: 6]);
  endproperty
  a_sc_mask_write: assert property (p_sc_mask_write)
    else $error("scalar masks not taken from their bits");

  property p_simd_mask_write;
    @(posedge clk) disable iff (!reset_n)
      wr_simd |=> simd_mask_r == $past(reg_wdata[fp_round_pkg::SIMD_MASK_LO +: 6]);
  endproperty
  a_simd_mask_write: assert property (p_simd_mask_write)
    else $error("simd masks not taken from their bits");

  property p_scalar_leaves_simd;
    @(posedge clk) disable iff (!reset_n)
      op_valid && !op_simd && !wr_simd |=> simd_flag_r == $past(simd_flag_r);
  endproperty
  a_scalar_leaves_simd: assert property (p_scalar_leaves_simd)
    else $error("scalar operation touched simd flags");

  // an operand trap must not leak result-side flags
  property p_pre_trap_stops_post;
    @(posedge clk) disable iff (!reset_n)
      op_valid && pre_trap |=> exc_seen_r[5:3] == 3'h0;
  endproperty
  a_pre_trap_stops_post: assert property (p_pre_trap_stops_post)
    else $error("post flags raised after an operand trap");

  property p_masked_dz_result;
    @(posedge clk) disable iff (!reset_n)
      op_valid && pre_dz && !pre_inv && !trap |=> res_r[30:0] == fp_round_pkg::MAG_INF;
  endproperty
  a_masked_dz_result: assert property (p_masked_dz_result)
    else $error("masked divide fault did not give infinity");

  property p_ovf_zero_finite;
    @(posedge clk) disable iff (!reset_n)
      op_valid && ovf && !pre_inv && !pre_dz && !trap && (rc_sel == fp_round_pkg::RC_ZERO)
        |=> res_r[30:0] == fp_round_pkg::MAG_MAX_FINITE;
  endproperty
  a_ovf_zero_finite: assert property (p_ovf_zero_finite)
    else $error("masked overflow in truncate mode gave infinity");

  property p_simd_sticky;
    @(posedge clk) disable iff (!reset_n)
      !wr_simd |=> (simd_flag_r & $past(simd_flag_r)) == $past(simd_flag_r);
  endproperty
  a_simd_sticky: assert property (p_simd_sticky)
    else $error("simd flag dropped without a software write");
endmodule : fp_round_flags

//--- common/fp_round_pkg.sv
// constants for the floating-point rounding and exception flag block
package fp_round_pkg;
  localparam logic [3:0] OFS_SCALAR_CTRL = 4'h0;
  localparam logic [3:0] OFS_SCALAR_STATUS = 4'h4;
  localparam logic [3:0] OFS_SIMD_CSR = 4'h8;
  localparam int BIT_INVALID = 0;
  localparam int BIT_SUBNORMAL = 1;
  localparam int BIT_DIVIDE = 2;
  localparam int BIT_OVERFLOW = 3;
  localparam int BIT_UNDERFLOW = 4;
  localparam int BIT_PRECISION = 5;
  localparam int SC_MASK_LO = 0;
  localparam int SC_RC_LO = 10;
  localparam int SIMD_FLAG_LO = 0;
  localparam int SIMD_MASK_LO = 7;
  localparam int SIMD_RC_LO = 13;
  localparam logic [5:0] MASK_RESET = 6'h3F;
  localparam logic [5:0] FLAG_RESET = 6'h00;
  localparam logic [1:0] RC_NEAREST = 2'h0;
  localparam logic [1:0] RC_DOWN = 2'h1;
  localparam logic [1:0] RC_UP = 2'h2;
  localparam logic [1:0] RC_ZERO = 2'h3;
  localparam logic [1:0] RC_RESET = RC_NEAREST;
  localparam logic [7:0] EXP_MAX = 8'hFF;
  localparam logic [9:0] EXP_OVF = 10'h0FF;
  localparam logic [31:0] QNAN_INDEFINITE = 32'hFFC00000;
  localparam logic [30:0] MAG_INF = 31'h7F800000;
  localparam logic [30:0] MAG_MAX_FINITE = 31'h7F7FFFFF;
endpackage : fp_round_pkg

//--- tb/test_fp_round_flags.sv
// self-checking bench for the fp rounding and exception flag block
`timescale 1ns/1ps
module test_fp_round_flags;
  localparam logic [31:0] ONE = 32'h3F800000;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic op_valid = 1'b0;
  logic op_simd = 1'b0;
  logic op_div = 1'b0;
  logic op_trunc_conv = 1'b0;
  logic op_no_round = 1'b0;
  logic res_sign = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] opa = 32'h0;
  logic [31:0] opb = 32'h0;
  logic [9:0] res_exp = 10'h0;
  logic [25:0] res_sig = 26'h0;
  logic [31:0] reg_rdata_r, res_r;
  logic [31:0] last_res = 32'h0;
  logic res_valid_r, res_write_r, handler_req_r;
  logic [5:0] exc_seen_r;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  // reference state: masks, rounding fields, sticky flags per unit
  int mask_m[2] = '{63, 63};
  int rc_m[2] = '{0, 0};
  int flag_m[2] = '{0, 0};

  always #10 clk = ~clk;

  fp_round_flags i_fp_round_flags (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_r, .op_valid, .op_simd, .op_div, .op_trunc_conv, .op_no_round, .opa, .opb,
    .res_sign, .res_exp, .res_sig, .res_valid_r, .res_write_r, .res_r, .handler_req_r,
    .exc_seen_r);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic bit snan(input logic [31:0] v);
    return v[30:23] == 8'hFF && !v[22] && v[21:0] != 22'h0;
  endfunction : snan

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == 4'h0) begin
      mask_m[0] = d[5:0];
      rc_m[0] = d[11:10];
    end
    if (a == 4'h4) flag_m[0] = d[5:0];
    if (a == 4'h8) begin
      flag_m[1] = d[5:0];
      mask_m[1] = d[12:7];
      rc_m[1] = d[14:13];
    end
  endtask : wr

  task automatic rd(input logic [3:0] a);
    logic [31:0] e;
    e = a == 4'h0 ? 32'(mask_m[0] | rc_m[0] << 10) : a == 4'h4 ? 32'(flag_m[0])
      : a == 4'h8 ? 32'(flag_m[1] | mask_m[1] << 7 | rc_m[1] << 13) : 32'h0;
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata_r, e, "register read");
  endtask : rd

  task automatic regs;
    for (int a = 0; a < 16; a += 4) rd(4'(a));
  endtask : regs

  // u selects the unit; model result is worked out before the op is sent
  task automatic op(input bit u, dv, tc, nr, input logic [31:0] a, b, input logic sg,
                    input logic [9:0] e, input logic [25:0] sig);
    int m, ex, r;
    bit g, s, inc, hr;
    logic [5:0] x;
    logic [31:0] er;
    m = sig[25:2];
    ex = $signed(e);
    r = tc ? 3 : rc_m[u];
    g = sig[1];
    s = sig[0];
    inc = !nr && (g | s) && (r == 0 ? g && (s || sig[2]) : r == 1 ? sg : r == 2 ? !sg : 1'b0);
    m = m + inc;
    if (m == 1 << 24) begin
      m = m >> 1;
      ex = ex + 1;
    end
    x = 6'h0;
    x[0] = dv && a[30:0] == b[30:0] && (a[30:0] == 31'h0 || a[30:0] == fp_round_pkg::MAG_INF)
      || snan(a) || snan(b);
    x[1] = a[30:23] == 8'h0 && a[22:0] != 23'h0 || b[30:23] == 8'h0 && b[22:0] != 23'h0;
    x[2] = dv && b[30:0] == 31'h0 && a[30:23] != 8'hFF && a[30:0] != 31'h0;
    hr = |(x[2:0] & ~mask_m[u][2:0]);
    // an unmasked operand fault stops the arithmetic, so no result faults follow
    if (!nr && !hr) x[5:3] = {g | s, (g | s) && ex <= 0, ex >= 255};
    hr = |(x & ~mask_m[u][5:0]);
    er = x[0] ? fp_round_pkg::QNAN_INDEFINITE : x[2] ? {a[31] ^ b[31], fp_round_pkg::MAG_INF}
      : x[3] ? {sg, (r == 0 || r == 1 && sg || r == 2 && !sg) ? fp_round_pkg::MAG_INF
      : fp_round_pkg::MAG_MAX_FINITE} : {sg, 8'(ex), 23'(m)};
    @(posedge clk);
    op_valid <= 1'b1;
    {op_simd, op_div, op_trunc_conv, op_no_round, opa, opb, res_sign, res_exp, res_sig} <=
      {u, dv, tc, nr, a, b, sg, e, sig};
    @(posedge clk);
    op_valid <= 1'b0;
    flag_m[u] |= x;
    #1;
    chk(32'(res_valid_r), 32'h1, "result valid");
    chk(32'({res_write_r, handler_req_r}), 32'({!hr, hr}), "handler");
    chk(32'(exc_seen_r), 32'(x), "exceptions");
    chk(res_r, hr ? last_res : er, "result");
    if (!hr) last_res = er;
  endtask : op

  // operand faults, subnormal plus precision, and a tiny result, all on the scalar unit
  task automatic specials;
    op(0, 1, 0, 0, ONE, 32'h80000000, 0, 10'h07F, 26'h2000000);
    op(0, 1, 0, 0, 32'h0, 32'h0, 0, 10'h07F, 26'h2000000);
    op(0, 1, 0, 0, 32'h7F800000, 32'hFF800000, 0, 10'h07F, 26'h2000000);
    op(0, 0, 0, 0, 32'h00000001, ONE, 1, 10'h07F, 26'h2000001);
    op(0, 0, 0, 0, 32'h7F800001, ONE, 0, 10'h07F, 26'h2000000);
    op(0, 0, 0, 0, ONE, ONE, 1, 10'h000, 26'h0000005);
  endtask : specials

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      finish_test;
    end
  end

  initial begin
    void'($urandom(48));
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    regs;
    // scalar and simd fields set to different modes in each pass
    for (int r = 0; r < 4; r++) begin
      wr(4'h0, 32'(r << 10 | 63));
      wr(4'h8, 32'((3 - r) << 13 | 63 << 7));
      for (int k = 0; k < 12; k++) begin
        op($urandom % 2, 0, k == 3, k == 5, ONE, ONE, $urandom % 2, 10'(1 + $urandom % 200),
          {1'b1, 23'($urandom), k < 2 ? 2'b10 : 2'($urandom)});
      end
      for (int s = 0; s < 2; s++) op(s, 0, 0, 0, ONE, ONE, s, 10'h0FF, 26'h3FFFFFE);
      regs;
    end
    wr(4'h4, 32'h0);
    wr(4'h8, 32'h1F80);
    wr(4'hC, 32'hFFFFFFFF);
    regs;
    specials;
    regs;
    wr(4'h0, 32'h0);
    op(0, 0, 0, 0, ONE, ONE, 0, 10'h07F, 26'h2000000);
    specials;
    op(0, 0, 0, 0, ONE, ONE, 0, 10'h07F, 26'h2000003);
    regs;
    finish_test;
  end
endmodule : test_fp_round_flags
